// file: core/edge_finder.v
// edge finder for a clock input sampled on pclk
// assumes the sampled clock is synchronous to pclk and slower than pclk / 2
module edge_finder (
  // system
  input  wire pclk,
  input  wire presetn,
  // sampled clock
  input  wire level_in,
  // edge pulses, one pclk cycle each
  output wire rise,
  output wire fall
);

  reg prev_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise = level_in & ~prev_reg;
  assign fall = ~level_in & prev_reg;

endmodule

// file: core/gpio_cell_defs.vh
// constants for the general-purpose pin cell: register map, control fields, modes
// assumes inclusion by the cell files only
`ifndef GPIO_CELL_DEFS_VH
`define GPIO_CELL_DEFS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CELL_CTRL_OFFSET   8'h00
`define CELL_STATUS_OFFSET 8'h04
`define CELL_CTRL_RESET    11'h000

// ****************************************
// control field positions
// ****************************************
`define CTRL_MODE_LO       0
`define CTRL_MODE_HI       1
`define CTRL_IN_REG        2
`define CTRL_OUT_REG       3
`define CTRL_IN_FALL       4
`define CTRL_OUT_FALL      5
`define CTRL_OE_FALL       6
`define CTRL_INVERT        7
`define CTRL_DOUBLE_EDGE_IO_IN       8
`define CTRL_DOUBLE_EDGE_IO_OUT      9
`define CTRL_RESYNC        10
`define CTRL_WIDTH         11

// ****************************************
// modes
// ****************************************
`define MODE_INPUT         2'h0
`define MODE_OUTPUT        2'h1
`define MODE_BIDIR         2'h2
`define MODE_CLKOUT        2'h3

`endif

// file: core/gpio_io_logic_cell.v
// I/O logic of one general-purpose pin cell, configured over APB
// assumes inclk, outclk and core_clk are synchronous inputs sampled on pclk
//
// What this block does
// [RQ1] input mode enables only the pad-to-core path, plain or registered
// [RQ2] registered input samples on the chosen input-clock edge
// [RQ3] alternate input path is always unregistered
// [RQ4] double-edge input samples pad on both input-clock edges
// [RQ5] output mode enables only core-to-pad path, registered on chosen output-clock edge
// [RQ6] output register value may be inverted before the pad
// [RQ7] double-edge output captures both edges, muxed onto one pad stream
// [RQ8] bidirectional mode enables input, output and enable paths with their clocks
// [RQ9] each register's edge is chosen separately in bidirectional mode
// [RQ10] input and output paths are registered independently
// [RQ11] clock-output mode drives the core clock onto the pad
// [RQ12] alternate input bypasses the core and feeds another block directly
// [RQ13] output enable switches the pad driver; off releases the pad
// [RQ14] input register captures pad; output register captures core value
// [RQ15] bit 0 carries rising-edge value, bit 1 falling-edge value
// [RQ16] resync delays the falling sample half a cycle onto the rising edge
// [RQ17] after reset the driver is disabled until output enable is asserted
`include "gpio_cell_defs.vh"

module gpio_io_logic_cell (
  // system and apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // cell clocks from the core
  input  wire        inclk,
  input  wire        outclk,
  input  wire        core_clk,
  // core side
  input  wire [1:0]  out_data,
  input  wire        oe_in,
  output reg  [1:0]  in_data,
  output reg         bypass_input_path,
  // pad side
  input  wire        pad_i,
  output reg         pad_o,
  output reg         pad_oe
);

  // ****************************************
  // configuration
  // ****************************************
  reg  [`CTRL_WIDTH-1:0] ctrl_reg;
  wire [1:0]             mode      = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire                   in_reg    = ctrl_reg[`CTRL_IN_REG];
  wire                   out_reg   = ctrl_reg[`CTRL_OUT_REG];
  wire                   in_fall   = ctrl_reg[`CTRL_IN_FALL];
  wire                   out_fall  = ctrl_reg[`CTRL_OUT_FALL];
  wire                   oe_fall   = ctrl_reg[`CTRL_OE_FALL];
  wire                   invert    = ctrl_reg[`CTRL_INVERT];
  wire                   double_edge_io_in   = ctrl_reg[`CTRL_DOUBLE_EDGE_IO_IN];
  wire                   double_edge_io_out  = ctrl_reg[`CTRL_DOUBLE_EDGE_IO_OUT];
  wire                   resync    = ctrl_reg[`CTRL_RESYNC];

  wire in_en  = (mode == `MODE_INPUT) | (mode == `MODE_BIDIR);   // see [RQ1] see [RQ8]
  wire out_en = (mode == `MODE_OUTPUT) | (mode == `MODE_BIDIR);  // see [RQ5] see [RQ8]

  // ****************************************
  // clock edges
  // ****************************************
  wire in_rise;
  wire in_fall_edge;
  wire out_rise;
  wire out_fall_edge;

  edge_finder u_in_edges (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (inclk),
    .rise     (in_rise),
    .fall     (in_fall_edge)
  );

  edge_finder u_out_edges (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (outclk),
    .rise     (out_rise),
    .fall     (out_fall_edge)
  );

  wire in_edge  = in_fall ? in_fall_edge : in_rise;    // see [RQ2] see [RQ9]
  wire out_edge = out_fall ? out_fall_edge : out_rise; // see [RQ5] see [RQ9]
  wire oe_edge  = oe_fall ? out_fall_edge : out_rise;  // see [RQ9]

  // ****************************************
  // input path
  // ****************************************
  reg       in_sample_reg;
  reg       rise_sample_reg;
  reg       falling_edge_sample_reg;
  reg       fall_delay_reg;
  reg [1:0] in_data_next;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sample_reg <= 1'b0;
    end else if (in_edge) begin
      in_sample_reg <= pad_i;                         // see [RQ2] see [RQ14]
    end
  end

  // double-edge capture pair, one register per input-clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sample_reg <= 1'b0;
    end else if (in_rise) begin
      rise_sample_reg <= pad_i;                       // see [RQ4]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falling_edge_sample_reg <= 1'b0;
    end else if (in_fall_edge) begin
      falling_edge_sample_reg <= pad_i;               // see [RQ4]
    end
  end

  // resync: the falling sample waits for the next rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_delay_reg <= 1'b0;
    end else if (in_rise) begin
      fall_delay_reg <= falling_edge_sample_reg;      // see [RQ16]
    end
  end

  always @* begin
    if (!in_en) begin
      in_data_next = 2'h0;                            // see [RQ1]
    end else if (double_edge_io_in) begin
      in_data_next = {resync ? fall_delay_reg : falling_edge_sample_reg, rise_sample_reg}; // see [RQ15]
    end else if (in_reg) begin
      in_data_next = {1'b0, in_sample_reg};           // see [RQ10]
    end else begin
      in_data_next = {1'b0, pad_i};
    end
  end

  // ****************************************
  // output path
  // ****************************************
  reg out_sample_reg;
  reg out_rise_reg;
  reg out_fall_reg;
  reg oe_sample_reg;
  reg out_value;
  reg pad_o_next;
  reg pad_oe_next;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sample_reg <= 1'b0;
    end else if (out_edge) begin
      out_sample_reg <= out_data[0];                  // see [RQ5] see [RQ14]
    end
  end

  // double-edge launch pair, one register per output-clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_rise_reg <= 1'b0;
    end else if (out_rise) begin
      out_rise_reg <= out_data[0];                    // see [RQ7] see [RQ15]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_fall_reg <= 1'b0;
    end else if (out_fall_edge) begin
      out_fall_reg <= out_data[1];                    // see [RQ7] see [RQ15]
    end
  end

  // enable register starts low so the pad floats until the core asks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_sample_reg <= 1'b0;                          // see [RQ17]
    end else if (oe_edge) begin
      oe_sample_reg <= oe_in;                         // see [RQ8]
    end
  end

  // outclk high shows the rising-edge word, low the falling one
  always @* begin
    if (double_edge_io_out) begin
      out_value = outclk ? out_rise_reg : out_fall_reg; // see [RQ7]
    end else if (out_reg) begin
      out_value = out_sample_reg ^ invert;            // see [RQ6] see [RQ10]
    end else begin
      out_value = out_data[0];
    end
  end

  always @* begin
    case (mode)
      `MODE_OUTPUT: begin
        pad_o_next  = out_value;
        pad_oe_next = 1'b1;
      end
      `MODE_BIDIR: begin
        pad_o_next  = out_value;
        pad_oe_next = out_reg ? oe_sample_reg : oe_in; // see [RQ13]
      end
      `MODE_CLKOUT: begin
        pad_o_next  = core_clk;                       // see [RQ11]
        pad_oe_next = 1'b1;
      end
      default: begin
        pad_o_next  = 1'b0;                           // see [RQ1]
        pad_oe_next = 1'b0;
      end
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // every path costs one pclk of latency so all outputs leave a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_data <= 2'h0;
    end else begin
      in_data <= in_data_next;
    end
  end

  // alternate path: no edge select and no mode gate, only the output flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_input_path <= 1'b0;
    end else begin
      bypass_input_path <= pad_i;                     // see [RQ3] see [RQ12]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_o <= 1'b0;
    end else begin
      pad_o <= pad_o_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_oe <= 1'b0;                                 // see [RQ17]
    end else begin
      pad_oe <= pad_oe_next;                          // see [RQ13]
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready;
  wire hit_ctl = (paddr == `CELL_CTRL_OFFSET);
  wire hit_sts = (paddr == `CELL_STATUS_OFFSET);

  // ready from the first edge after reset: every access is zero-wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // read data and error latched in setup, so access finishes in one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~(hit_ctl | (hit_sts & ~pwrite));
      if (hit_ctl) begin
        prdata <= {21'h00000, ctrl_reg};
      end else if (hit_sts) begin
        prdata <= {27'h000000, pad_oe, pad_o, in_data, pad_i};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // only the control word is writable; a status write just raises pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `CELL_CTRL_RESET;
    end else if (access & pwrite & hit_ctl) begin
      ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
    end
  end

endmodule

// file: test/core_fabric_model.sv
// core-side partner: output data, enable and a core clock for the cell
// assumes outclk is slow against pclk
module core_fabric_model (
  // system
  input  logic       pclk,
  input  logic       presetn,
  input  logic       outclk,
  // to the cell
  output logic [1:0] out_data,
  output logic       oe_in,
  output logic       core_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] h_reg;
  logic [1:0] k_reg;
  integer     seed = 32'h3885;
  // new data three samples after outclk rises, clear of both edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_reg <= 3'h0;
      k_reg <= 2'h0;
      {oe_in, out_data} <= 3'h0;
    end else begin
      h_reg <= {h_reg[1:0], outclk};
      k_reg <= k_reg + 2'h1;
      if (h_reg == 3'h3)
        {oe_in, out_data} <= 3'($random(seed));
    end
  end
  assign core_clk = k_reg[1];
endmodule

// file: test/gpio_cell_props.sv
// checker for the pin cell, watching its top-level ports only
// assumes one clock, pclk, and presetn clearing every flop
module gpio_cell_props (
  // apb
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  // core side
  input logic        inclk,
  input logic        core_clk,
  input logic [1:0]  out_data,
  input logic        oe_in,
  input logic [1:0]  in_data,
  // pad side
  input logic        bypass_input_path,
  input logic        pad_i,
  input logic        pad_o,
  input logic        pad_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // control shadow and quiet-clock count
  // ****
  logic [10:0] c_reg;
  logic [2:0]  n_reg;
  // pready doubles as "one edge since reset", so $past never sees reset values
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_reg <= 11'h000;
      n_reg <= 3'h0;
    end else begin
      if (psel && penable && pwrite && paddr == 8'h00)
        c_reg <= pwdata[10:0];
      n_reg <= ($changed(inclk) || psel) ? 3'h0 : n_reg + {2'h0, n_reg != 3'h7};
    end
  end
  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_bad_addr_err: assert property (psel && !penable |=> pslverr == ($past(paddr) != 8'h00
    && ($past(paddr) != 8'h04 || $past(pwrite)))) else $error("slave error wrong");
  a_bypass_comb: assert property (pready |-> bypass_input_path == $past(pad_i))
    else $error("bypass path not plain");
  a_in_plain: assert property (pready && $stable(c_reg) && !c_reg[0] && !c_reg[2]
    && !c_reg[8] |-> in_data[0] == $past(pad_i)) else $error("plain input wrong");
  a_in_no_drive: assert property (pready && $stable(c_reg) && c_reg[1:0] == 2'h0
    |-> !pad_oe) else $error("pad driven in input mode");
  a_out_plain: assert property (pready && $stable(c_reg) && c_reg[1:0] == 2'h1 && !c_reg[3]
    && !c_reg[9] |-> pad_o == $past(out_data[0]) && pad_oe) else $error("plain output wrong");
  a_out_no_in: assert property (pready && $stable(c_reg) && c_reg[0] |-> in_data == 2'h0)
    else $error("input path open in output mode");
  a_clk_out: assert property (pready && $stable(c_reg) && c_reg[1:0] == 2'h3
    |-> pad_o == $past(core_clk)) else $error("clock not on pad");
  a_oe_follows: assert property (pready && $stable(c_reg) && c_reg[1:0] == 2'h2 && !c_reg[3]
    |-> pad_oe == $past(oe_in)) else $error("enable not followed");
  // two quiet edges suffice: a captured sample reaches in_data one edge later
  a_in_reg_hold: assert property (n_reg >= 3'h2 && c_reg[2] && !c_reg[8]
    |-> $stable(in_data[0])) else $error("input register moved without clock edge");
endmodule
bind gpio_io_logic_cell gpio_cell_props props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .inclk, .core_clk, .out_data, .oe_in, .in_data, .bypass_input_path, .pad_i, .pad_o, .pad_oe);

// file: test/gpio_io_logic_cell_tb.sv
// self-checking bench for the pin cell: apb setup, pad and clock stimulus
// assumes a zero-wait apb slave and cell clocks sampled on pclk
module gpio_io_logic_cell_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, inclk, outclk, pad_i, er;
  logic        pready, pslverr, pad_o, pad_oe, bypass_input_path, oe_in, core_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  out_data, in_data;
  logic [31:0] cin [5] = '{32'h004, 32'h014, 32'h006, 32'h100, 32'h500};
  logic [31:0] cout [6] = '{32'h009, 32'h0AD, 32'h02A, 32'h201, 32'h001, 32'h003};
  integer      seed = 32'h3885, bad_count = 0, n_checks = 0, cyc = 0;
  gpio_io_logic_cell DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .inclk, .outclk, .core_clk, .out_data, .oe_in, .in_data, .bypass_input_path, .pad_i, .pad_o, .pad_oe);
  core_fabric_model partner (.pclk, .presetn, .outclk, .out_data, .oe_in, .core_clk);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ****
  // tasks
  // ****
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [1:0] in_exp(input logic dd, input logic hi, input logic lo);
    return dd ? {hi, lo} : {1'b0, lo};
  endfunction
  function automatic logic [31:0] sts_exp(input logic oe, input logic o, input logic [1:0] d, input logic p);
    return {27'h000000, oe, o, d, p};
  endfunction
  // one idle edge after each transfer, so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic run_in(input logic [31:0] c);
    logic b, r, e0, e1, p;
    apb(1'b1, 8'h00, c);
    for (int i = 0; i < 16; i++) begin
      b = 1'($random(seed));
      pad_i <= b;
      tick(2);
      r = ~inclk;
      inclk <= r;
      if (c[8]) begin
        if (r) e0 = b;
        if (r && c[10]) e1 = p;
        if (!r) p = b;
        if (!r && !c[10]) e1 = b;
      end else if (r != c[4])
        e0 = b;
      tick(3);
      @(negedge pclk);
      if (i > 1)
        cmp("in_data", in_exp(c[8], e1, e0), in_data & {c[8], 1'b1});
      @(posedge pclk);
    end
  endtask
  task automatic run_out(input logic [31:0] c);
    logic r, eo, eoe;
    logic [2:0] d;
    apb(1'b1, 8'h00, c);
    for (int i = 0; i < 16; i++) begin
      r = ~outclk;
      outclk <= r;
      pad_i <= 1'($random(seed));
      tick(1);
      d = {oe_in, out_data};
      if (c[9]) eo = r ? d[0] : d[1];
      else if (r != c[5]) eo = d[0] ^ c[7];
      if (c[1:0] == 2'h1) eoe = 1'b1;
      else if (r != c[6]) eoe = d[2];
      tick(2);
      @(negedge pclk);
      if (i > 1 && (c[3] || c[9]))
        cmp("pad", {eoe, eo}, {pad_oe, pad_o});
      @(posedge pclk);
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, inclk, outclk, pad_i} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick(5);
    presetn <= 1'b1;
    repeat (20) begin
      tick(1);
      pad_i <= 1'($random(seed));
    end
    apb(1'b0, 8'h00, 32'h0);
    cmp("ctrl", 32'h0, rd);
    cmp("oe", 32'h0, {31'h0, pad_oe});
    apb(1'b0, 8'h04, 32'h0);
    cmp("status", sts_exp(1'b0, 1'b0, {1'b0, pad_i}, pad_i), rd);
    cmp("slverr", 32'h0, {31'h0, er});
    apb(1'b1, 8'h00, 32'h7FE);
    apb(1'b0, 8'h00, 32'h0);
    cmp("ctrl", 32'h7FE, rd);
    apb(1'b1, 8'h04, 32'h1F);
    cmp("slverr", 32'h1, {31'h0, er});
    apb(1'b0, 8'h08, 32'h0);
    cmp("slverr", 32'h1, {31'h0, er});
    foreach (cin[k]) run_in(cin[k]);
    foreach (cout[k]) run_out(cout[k]);
    test_done;
  end
endmodule
